// File: logic/rhr_handler.sv
// Purpose: decode halt and protocol-request frames and send the fixed answer
// Assumes: rx bytes come from same-clock deframer; CRC verdict on last byte
// Notes: emits answer bytes one per cycle while the link accepts them
// What this block does
// - Halt command 0x5000 moves tag to HALT
// - No response for 1 ms after halt
// - Upper parameter nibble decodes reader frame size
// - Reserved size codes 9..E treated as F
// - Lower parameter nibble becomes logical address
// - Address 15: silence, fall back to idle/halt
// - Answer length byte is five
// - Format byte 0x7 high nibble plus FSCI
// - Timing byte: FWI high, SFGI zero low
// - Option byte sent as all zeros
// - No historical bytes after option byte
`timescale 1ns/1ps
module rhr_handler #(
   parameter int unsigned QUIET_CYC = rhr_pkg::HALT_QUIET_CYC,
   parameter logic [3:0] FSCI = 4'h8,
   parameter logic [3:0] FWI = 4'h4
) (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   // Activation state from the selection logic
   input wire logic i_selected,
   input wire logic i_was_halted,
   // Received frame bytes
   input wire logic i_rx_valid,
   input wire rhr_pkg::rhr_rx_t i_rx,
   input wire logic i_rx_crc_ok,
   // Answer bytes
   input wire logic i_tx_ready,
   output logic o_tx_valid,
   output logic [7:0] o_tx_data,
   output logic o_tx_last,
   // Status
   output logic [2:0] o_state,
   output logic o_quiet,
   output logic [3:0] o_fsdi,
   output logic [3:0] o_cid
);
   import rhr_pkg::*;

   function automatic logic [3:0] fsdi_norm(input logic [3:0] code);
      fsdi_norm = (code > FSDI_MAX_STD) ? FSDI_256 : code;
   endfunction

   typedef enum logic [1:0] {
      RHR_CMD_NONE = 2'b00,
      RHR_CMD_HALT = 2'b01,
      RHR_CMD_RATS = 2'b10
   } rhr_cmd_t;

   rhr_state_t state_r, state_nxt;
   rhr_cmd_t cmd_r, cmd_nxt;
   logic [7:0] b0_r, b0_nxt, b1_r, b1_nxt;
   logic [1:0] cnt_r, cnt_nxt;
   logic [31:0] quiet_r, quiet_nxt;
   logic [2:0] idx_r, idx_nxt;
   logic sending_r, sending_nxt;
   logic [3:0] fsdi_r, fsdi_nxt, cid_r, cid_nxt;
   logic tv_r, tv_nxt, tl_r, tl_nxt;
   logic [7:0] td_r, td_nxt;
   logic [7:0] ats_byte;

   always_comb begin
      unique case (idx_r)
         3'h0: ats_byte = ATS_TL;
         3'h1: ats_byte = {ATS_T0_HI, FSCI};
         3'h2: ats_byte = ATS_TA;
         3'h3: ats_byte = {FWI, ATS_SFGI};
         3'h4: ats_byte = ATS_TC;
         default: ats_byte = ATS_TC;
      endcase
   end

   always_comb begin
      state_nxt = state_r;
      cmd_nxt = cmd_r;
      b0_nxt = b0_r;
      b1_nxt = b1_r;
      cnt_nxt = cnt_r;
      quiet_nxt = (quiet_r != 32'h0) ? quiet_r - 32'h1 : quiet_r;
      idx_nxt = idx_r;
      sending_nxt = sending_r;
      fsdi_nxt = fsdi_r;
      cid_nxt = cid_r;
      tv_nxt = tv_r;
      td_nxt = td_r;
      tl_nxt = tl_r;
      if (i_selected && state_r == RHR_IDLE) begin
         state_nxt = RHR_ACTIVE;
      end
      if (i_rx_valid) begin
         if (i_rx.first) begin
            b0_nxt = i_rx.data;
            cnt_nxt = 2'h1;
         end else if (cnt_r == 2'h1) begin
            b1_nxt = i_rx.data;
            cnt_nxt = 2'h2;
         end else if (cnt_r != 2'h0) begin
            cnt_nxt = 2'h3;
         end
         if (i_rx.last && i_rx_crc_ok && !sending_r) begin
            if ({b0_nxt, b1_nxt} == {HALT_CODE_B0, HALT_CODE_B1}
                && cnt_nxt == 2'h2) begin
               state_nxt = RHR_HALT;
               quiet_nxt = QUIET_CYC;
               cmd_nxt = RHR_CMD_HALT;
            end else if (b0_nxt == RATS_START && cnt_nxt == 2'h2
                         && state_r == RHR_ACTIVE && quiet_r == 32'h0) begin
               if (b1_nxt[3:0] == CID_FORBIDDEN) begin
                  state_nxt = i_was_halted ? RHR_HALT : RHR_IDLE;
               end else begin
                  fsdi_nxt = fsdi_norm(b1_nxt[7:4]);
                  cid_nxt = b1_nxt[3:0];
                  state_nxt = RHR_PROTO;
                  cmd_nxt = RHR_CMD_RATS;
                  sending_nxt = 1'b1;
                  idx_nxt = 3'h0;
               end
            end
         end
      end
      if (sending_r && (!tv_r || i_tx_ready)) begin
         tv_nxt = 1'b1;
         td_nxt = ats_byte;
         tl_nxt = (idx_r == ATS_LAST);
         idx_nxt = idx_r + 3'h1;
         sending_nxt = (idx_r != ATS_LAST);
      end else if (tv_r && i_tx_ready) begin
         tv_nxt = 1'b0;
         tl_nxt = 1'b0;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         state_r <= RHR_IDLE;
         cmd_r <= RHR_CMD_NONE;
         b0_r <= 8'h00;
         b1_r <= 8'h00;
         cnt_r <= 2'h0;
         quiet_r <= 32'h0;
         idx_r <= 3'h0;
         sending_r <= 1'b0;
         fsdi_r <= 4'h0;
         cid_r <= 4'h0;
         tv_r <= 1'b0;
         td_r <= 8'h00;
         tl_r <= 1'b0;
         o_state <= 3'h0;
         o_quiet <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cmd_r <= cmd_nxt;
         b0_r <= b0_nxt;
         b1_r <= b1_nxt;
         cnt_r <= cnt_nxt;
         quiet_r <= quiet_nxt;
         idx_r <= idx_nxt;
         sending_r <= sending_nxt;
         fsdi_r <= fsdi_nxt;
         cid_r <= cid_nxt;
         tv_r <= tv_nxt;
         td_r <= td_nxt;
         tl_r <= tl_nxt;
         o_state <= state_nxt;
         o_quiet <= (quiet_nxt != 32'h0);
      end
   end

   assign o_tx_valid = tv_r;
   assign o_tx_data = td_r;
   assign o_tx_last = tl_r;
   assign o_fsdi = fsdi_r;
   assign o_cid = cid_r;

   a_halt_enters: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      (i_rx_valid && i_rx.last && i_rx_crc_ok && !sending_r && cnt_r == 2'h1
       && b0_r == HALT_CODE_B0 && i_rx.data == HALT_CODE_B1 && !i_rx.first)
      |=> state_r == RHR_HALT)
      else $error("halt frame did not enter halt state");
   // Address 15 may also drop into HALT, so only a halt frame loads the quiet time
   a_quiet_loaded: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      (i_rx_valid && i_rx.last && i_rx_crc_ok && !sending_r && cnt_r == 2'h1
       && b0_r == HALT_CODE_B0 && i_rx.data == HALT_CODE_B1 && !i_rx.first)
      |=> quiet_r == QUIET_CYC)
      else $error("quiet time not loaded on halt");
   a_quiet_silent: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      (quiet_r != 32'h0) |-> !sending_nxt || sending_r)
      else $error("answer started during quiet time");
   a_fsdi_range: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      $changed(fsdi_r) |-> (fsdi_r <= FSDI_MAX_STD || fsdi_r == FSDI_256))
      else $error("reserved frame size code kept");
   a_cid_never_15: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      state_r == RHR_PROTO |-> cid_r != CID_FORBIDDEN)
      else $error("forbidden address accepted");
   a_tl_first: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      $rose(sending_r) |-> ##[1:300] (tv_r && td_r == ATS_TL))
      else $error("answer length byte wrong");
   a_frame_len: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      (tv_r && tl_r) |-> (td_r == ATS_TC && idx_r == ATS_LAST + 3'h1))
      else $error("answer did not end after option byte");
   a_bad_crc_quiet: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      (i_rx_valid && i_rx.last && !i_rx_crc_ok && !sending_r) |=> !sending_r)
      else $error("bad frame answered");
   a_need_select: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      $rose(sending_r) |-> $past(state_r) == RHR_ACTIVE)
      else $error("answer outside selected state");

   // Answer bytes hold while the link stalls
   a_tx_stands: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      (tv_r && !i_tx_ready)
      |=> (tv_r && $stable(td_r) && $stable(tl_r)))
      else $error("answer byte changed while stalled");

   // Each answer byte against its slot; idx_r already points past it
   a_tl_byte: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      (tv_r && idx_r == 3'h1)
      |-> (td_r == ATS_TL))
      else $error("length byte wrong");
   a_t0_byte: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      (tv_r && idx_r == 3'h2)
      |-> (td_r == {ATS_T0_HI, FSCI}))
      else $error("format byte wrong");
   a_ta_byte: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      (tv_r && idx_r == 3'h3)
      |-> (td_r == ATS_TA))
      else $error("rate byte wrong");
   a_tb_byte: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      (tv_r && idx_r == 3'h4)
      |-> (td_r == {FWI, ATS_SFGI}))
      else $error("timing byte wrong");
   a_tc_byte: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      (tv_r && idx_r == ATS_LAST + 3'h1)
      |-> (td_r == ATS_TC && tl_r))
      else $error("option byte wrong");
   a_last_only_tc: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      (tv_r && idx_r != ATS_LAST + 3'h1)
      |-> !tl_r)
      else $error("answer ended early");
   a_idx_range: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      idx_r <= ATS_LAST + 3'h1)
      else $error("answer index out of range");

   // Parameter byte fields, taken from the decisive byte
   a_fsdi_std: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      ($rose(sending_r) && $past(i_rx.data[7:4]) <= FSDI_MAX_STD)
      |-> (fsdi_r == $past(i_rx.data[7:4])))
      else $error("frame size code not kept");
   a_fsdi_rsv: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      ($rose(sending_r) && $past(i_rx.data[7:4]) > FSDI_MAX_STD)
      |-> (fsdi_r == FSDI_256))
      else $error("reserved frame size code not mapped");
   a_cid_taken: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      $rose(sending_r)
      |-> (cid_r == $past(i_rx.data[3:0])))
      else $error("logical address not taken");
   a_cid15_silent: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      (i_rx_valid && i_rx.last && i_rx_crc_ok && !sending_r && cnt_r == 2'h1
       && b0_r == RATS_START && !i_rx.first && i_rx.data[3:0] == CID_FORBIDDEN
       && state_r == RHR_ACTIVE && quiet_r == 32'h0)
      |=> (!sending_r && state_r == ($past(i_was_halted) ? RHR_HALT : RHR_IDLE)))
      else $error("address 15 not refused");

   // Quiet time and state bookkeeping
   a_quiet_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      (quiet_r > 32'h1) |=> (quiet_r != 32'h0))
      else $error("quiet time ended early");
   a_quiet_flag: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      o_quiet == (quiet_r != 32'h0))
      else $error("quiet flag out of step");
   a_send_proto: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      sending_r |-> (state_r == RHR_PROTO))
      else $error("answer outside protocol state");
   a_idle_silent: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      (state_r == RHR_IDLE) |-> !sending_r)
      else $error("answer while idle");
   a_bad_crc_keep: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      (i_rx_valid && i_rx.last && !i_rx_crc_ok && state_r != RHR_IDLE)
      |=> ($stable(state_r) && $stable(cid_r) && $stable(fsdi_r)))
      else $error("bad frame changed state");

   c_halt: cover property (@(posedge i_clk_sys) disable iff (!i_rstn)
      state_r == RHR_HALT && quiet_r == 32'h1);
   c_ats: cover property (@(posedge i_clk_sys) disable iff (!i_rstn)
      tv_r && tl_r && i_tx_ready);
   c_cid15: cover property (@(posedge i_clk_sys) disable iff (!i_rstn)
      i_rx_valid && i_rx.last && b0_r == RATS_START && i_rx.data[3:0] == CID_FORBIDDEN);
   c_fsdi_res: cover property (@(posedge i_clk_sys) disable iff (!i_rstn)
      $changed(fsdi_r) && fsdi_r == FSDI_256);
   c_tx_stall: cover property (@(posedge i_clk_sys) disable iff (!i_rstn)
      tv_r && !i_tx_ready);
endmodule

// File: pkg/rhr_pkg.sv
// Purpose: constants and types for the halt and protocol-request handler
// Assumes: frames arrive already deframed, byte by byte, with CRC verdict
// Notes: clock is 100 MHz
package rhr_pkg;
   localparam int unsigned CLK_HZ = 100000000;
   localparam int unsigned HALT_QUIET_US = 1000;
   localparam int unsigned HALT_QUIET_CYC = (HALT_QUIET_US * (CLK_HZ / 1000000));
   localparam logic [7:0] HALT_CODE_B0 = 8'h50;
   localparam logic [7:0] HALT_CODE_B1 = 8'h00;
   localparam logic [7:0] RATS_START = 8'hE0;
   localparam logic [3:0] FSDI_MAX_STD = 4'h8;
   localparam logic [3:0] FSDI_256 = 4'hF;
   localparam logic [3:0] CID_FORBIDDEN = 4'hF;
   localparam logic [7:0] ATS_TL = 8'h05;
   localparam logic [3:0] ATS_T0_HI = 4'h7;
   localparam logic [7:0] ATS_TA = 8'h80;
   localparam logic [3:0] ATS_SFGI = 4'h0;
   localparam logic [7:0] ATS_TC = 8'h00;
   localparam logic [2:0] ATS_LAST = 3'h4;

   typedef enum logic [2:0] {
      RHR_IDLE = 3'b000,
      RHR_ACTIVE = 3'b001,
      RHR_HALT = 3'b010,
      RHR_PROTO = 3'b011
   } rhr_state_t;

   typedef struct packed {
      logic [7:0] data;
      logic first;
      logic last;
   } rhr_rx_t;

   typedef struct packed {
      logic [7:0] data;
      logic valid;
      logic last;
   } rhr_tx_t;
endpackage

// File: sim/rhr_reader.sv
// Purpose: reader-side model sending request frames and stalling answers
// Assumes: frames already deframed, CRC verdict given with last byte
// Notes: idle data shows inverse of last byte
`timescale 1ns/1ps
module rhr_reader import rhr_pkg::*; (
   // Clock
   input wire logic i_clk_sys,
   // Frame bytes and answer acceptance
   output logic o_rx_valid,
   output rhr_rx_t o_rx,
   output logic o_crc_ok,
   output logic o_ready
);
   initial begin
      o_rx_valid = 1'b0;
      o_rx = '0;
      o_crc_ok = 1'b0;
      o_ready = 1'b0;
   end
   // Random stalls on the answer side
   always @(posedge i_clk_sys) begin
      o_ready <= ($urandom % 3) != 0;
   end
   task automatic send(input logic [7:0] b0, input logic [7:0] b1, input logic ok);
      @(posedge i_clk_sys);
      o_rx_valid <= 1'b1;
      o_rx <= '{data: b0, first: 1'b1, last: 1'b0};
      o_crc_ok <= 1'b0;
      @(posedge i_clk_sys);
      o_rx <= '{data: b1, first: 1'b0, last: 1'b1};
      o_crc_ok <= ok;
      @(posedge i_clk_sys);
      o_rx_valid <= 1'b0;
      o_rx <= '{data: ~b1, first: 1'b0, last: 1'b0};
      o_crc_ok <= ~ok;
   endtask
endmodule

// File: sim/testbench.sv
// Purpose: self-checking bench for the halt and protocol-request handler
// Assumes: quiet time shortened to 50 cycles
// Notes: one request per reset, since a second one is refused
`timescale 1ns/1ps
module testbench;
   import rhr_pkg::*;
   logic i_clk_sys, i_rstn, sel, hlt, rxv, crc, rdy, txv, txl, q;
   rhr_rx_t rx;
   logic [7:0] txd;
   logic [2:0] st;
   logic [3:0] fsdi, cid, c;
   int err_count = 0, compares = 0, cyc = 0, w;
   rhr_handler #(.QUIET_CYC(50)) rhr_handler_inst (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn),
      .i_selected(sel), .i_was_halted(hlt), .i_rx_valid(rxv), .i_rx(rx), .i_rx_crc_ok(crc),
      .i_tx_ready(rdy), .o_tx_valid(txv), .o_tx_data(txd), .o_tx_last(txl), .o_state(st),
      .o_quiet(q), .o_fsdi(fsdi), .o_cid(cid));
   rhr_reader rhr_reader_inst (.i_clk_sys(i_clk_sys), .o_rx_valid(rxv), .o_rx(rx),
      .o_crc_ok(crc), .o_ready(rdy));
   initial begin
      i_clk_sys = 1'b0;
      forever #5 i_clk_sys = ~i_clk_sys;
   end
   always @(posedge i_clk_sys) begin
      cyc++;
      if (cyc > 20000) begin
         err_count++;
         summarize();
      end
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic summarize();
      $display("compares=%0d err_count=%0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic rst(input logic h);
      i_rstn <= 1'b0;
      sel <= 1'b0;
      hlt <= h;
      repeat (16) @(posedge i_clk_sys);
      i_rstn <= 1'b1;
      sel <= 1'b1;
      @(posedge i_clk_sys);
   endtask
   function automatic logic [7:0] ats(input int i);
      logic [7:0] t[5] = '{8'h05, 8'h78, 8'h80, 8'h40, 8'h00};
      return t[i];
   endfunction
   // Collects answer bytes taken over a fixed window
   task automatic answer(input int n);
      int k;
      k = 0;
      repeat (40) begin
         @(posedge i_clk_sys);
         if (txv === 1'b1 && rdy === 1'b1) begin
            check(txd, ats(k));
            check({7'h0, txl}, {7'h0, k == 4});
            k++;
         end
      end
      check(8'(k), 8'(n));
   endtask
   initial begin
      i_rstn = 1'b0;
      sel = 1'b0;
      hlt = 1'b0;
      void'($urandom(32'h8571));
      for (int f = 0; f < 16; f++) begin
         rst(1'b0);
         c = 4'($urandom % 15);
         rhr_reader_inst.send(8'hE0, {4'(f), c}, 1'b1);
         answer(5);
         check({4'h0, fsdi}, (f > 8 && f < 15) ? 8'h0F : 8'(f));
         check({4'h0, cid}, {4'h0, c});
         rhr_reader_inst.send(8'hE0, 8'h11, 1'b1);
         answer(0);
      end
      for (int h = 0; h < 2; h++) begin
         rst(1'(h));
         rhr_reader_inst.send(8'hE0, 8'h8F, 1'b1);
         sel <= 1'b0;
         answer(0);
         check({5'h0, st}, h ? 8'h02 : 8'h00);
      end
      rst(1'b0);
      rhr_reader_inst.send(8'hE0, 8'h80, 1'b0);
      answer(0);
      rhr_reader_inst.send(8'h50, 8'h00, 1'b0);
      @(posedge i_clk_sys);
      check({5'h0, st}, 8'h01);
      rhr_reader_inst.send(8'h50, 8'h00, 1'b1);
      @(posedge i_clk_sys);
      check({5'h0, st}, 8'h02);
      w = 0;
      while (q === 1'b1 && w < 100) begin
         @(posedge i_clk_sys);
         w++;
      end
      check(8'(w >= 47 && w <= 50), 8'h01);
      rhr_reader_inst.send(8'hE0, 8'h80, 1'b1);
      answer(0);
      summarize();
   end
endmodule
